// ===== src/ssf_regs.svh
// Register offsets, field positions, reset values for the spindle status flags
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// ****************************************************************
// Register byte offsets on the APB slave
// ****************************************************************
`define SSF_OFF_LEVEL      8'h00
`define SSF_OFF_HYST       8'h04
`define SSF_OFF_WINDOW     8'h08
`define SSF_OFF_STATUS     8'h0C
`define SSF_OFF_IRQ_STS    8'h10
`define SSF_OFF_IRQ_MASK   8'h14

// ****************************************************************
// Interrupt bit positions and widths
// ****************************************************************
`define SSF_IRQ_SPEED      0
`define SSF_IRQ_REDET      1
`define SSF_IRQ_INPOS      2
`define SSF_IRQ_W          3
`define SSF_CFG_W          16

// ****************************************************************
// Reset values
// ****************************************************************
`define SSF_RST_LEVEL      16'h0000
`define SSF_RST_HYST       16'h0000
`define SSF_RST_WINDOW     16'h0000
`define SSF_RST_MASK       3'h0
`define SSF_RST_SPEED_FLAG 1'b1
`define SSF_RST_STATUS     16'h0000
`define SSF_RST_DATA       32'h00000000
`define SSF_MAINT_HI_ZERO  9'h000
`define SSF_IRQ_NONE       3'h0

`endif

// ===== src/ssf_pkg.sv
// Types shared by the spindle status flag block
package ssf_pkg;

  // ****************************************************************
  // Status word seen by the numerical controller
  // ****************************************************************
  typedef struct packed {
    logic       second_inposition_flag;
    logic       holding_boost_active;
    logic       zero_redetect_done;
    logic       gain_set2_active;
    logic       excitation_set2_active;
    logic [8:0] maint_hi;
    logic       speed_detect_output;
    logic       maint_lo;
  } ssf_status_t;

  // ****************************************************************
  // Feedback from the motor control loop
  // ****************************************************************
  typedef struct packed {
    logic signed [15:0] motor_speed;
    logic signed [15:0] position_droop;
    logic               excitation_set2_in_use;
    logic               gain_set2_in_use;
    logic               observer_running;
    logic               redetect_finished;
  } ssf_drive_fb_t;

  // ****************************************************************
  // Zero-point re-detection handshake states
  // ****************************************************************
  typedef enum logic [1:0] {
    SSF_RD_IDLE = 2'b00,
    SSF_RD_BUSY = 2'b01,
    SSF_RD_DONE = 2'b10
  } ssf_redet_state_t;

endpackage

// ===== src/ssf_speed_detect.sv
// Speed detection comparator with hysteresis on absolute speed
`include "ssf_regs.svh"
module ssf_speed_detect
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Control cycle strobe
  input  wire logic                    update,
  // Speed and thresholds
  input  wire logic signed [15:0]      speed,
  input  wire logic [`SSF_CFG_W-1:0]   level,
  input  wire logic [`SSF_CFG_W-1:0]   hyst,
  // Flag and its next value
  output logic                         flag,
  output logic                         flag_next
);

  logic              flag_reg;
  wire logic [16:0]  speed_ext  = {speed[15], speed};
  // Magnitude, so both directions behave the same
  wire logic [16:0]  speed_abs  = speed[15] ? (17'h00000 - speed_ext) : speed_ext;
  wire logic [16:0]  upper      = {1'b0, level} + {1'b0, hyst};
  wire logic         rise_above = speed_abs > upper;
  wire logic         fall_below = speed_abs < {1'b0, level};

  // Hold between thresholds
  assign flag_next = rise_above ? 1'b0 :
                     fall_below ? 1'b1 :
                     flag_reg;
  assign flag      = flag_reg;

  // Flag state
  always_ff @(posedge clk)
  begin
    if (srst)
      flag_reg <= `SSF_RST_SPEED_FLAG;
    else if (update)
      flag_reg <= flag_next;
  end

endmodule

// ===== src/ssf_sticky.sv
// Sticky event bits, set wins over write-one-to-clear
module ssf_sticky
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Events and clears
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // Held bits
  output logic [WIDTH-1:0]      sts
);

  logic [WIDTH-1:0] sts_reg;
  wire  logic [WIDTH-1:0] sts_next = (sts_reg & ~clr) | set;

  // Sticky storage
  always_ff @(posedge clk)
  begin
    if (srst)
      sts_reg <= '0;
    else
      sts_reg <= sts_next;
  end

  assign sts = sts_reg;

endmodule

// ===== src/ssf_top.sv
// Spindle status flag block with APB registers and interrupt
// Summary of operation
// - Clear speed flag above level plus hysteresis
// - Set speed flag below detect level
// - Compare absolute speed, direction independent
// - Excitation indicator high for set two
// - Excitation indicator low for set one
// - Gain indicator high for gain group two
// - Gain indicator low for gain group one
// - Done flag only after requested re-detection finishes
// - Dropping request clears done flag
// - Boost flag while observer runs on request
// - Second in-position when droop inside window
//
// Chosen here: the placing of the registers and register access over APB.
`include "ssf_regs.svh"
module ssf_top
  import ssf_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // APB slave
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Numerical controller side
  input  wire logic                  redetect_request,
  input  wire logic                  holding_boost_request,
  output ssf_pkg::ssf_status_t       status_word,
  // Motor control loop side
  input  wire logic                  ctrl_cycle_tick,
  input  wire ssf_pkg::ssf_drive_fb_t drive_fb,
  output logic                       redetect_busy,
  // Interrupt
  output logic                       irq
);

  import ssf_pkg::*;

  // ****************************************************************
  // State declarations
  // ****************************************************************
  logic [`SSF_CFG_W-1:0] level_reg;
  logic [`SSF_CFG_W-1:0] hyst_reg;
  logic [`SSF_CFG_W-1:0] window_reg;
  logic [`SSF_IRQ_W-1:0] mask_reg;
  ssf_status_t           status_reg;
  ssf_status_t           status_next;
  ssf_redet_state_t      redet_reg;
  ssf_redet_state_t      redet_next;
  logic                  redetect_busy_reg;
  logic                  irq_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic                  speed_flag;
  logic                  speed_flag_next;
  logic [`SSF_IRQ_W-1:0] irq_sts;

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Phase qualifiers
  wire logic setup_phase = psel & ~penable;
  wire logic access_done = psel & penable & pready_reg;
  wire logic wr_en       = access_done & pwrite;

  // Address selects
  wire logic sel_level   = paddr == `SSF_OFF_LEVEL;
  wire logic sel_hyst    = paddr == `SSF_OFF_HYST;
  wire logic sel_window  = paddr == `SSF_OFF_WINDOW;
  wire logic sel_status  = paddr == `SSF_OFF_STATUS;
  wire logic sel_irq_sts = paddr == `SSF_OFF_IRQ_STS;
  wire logic sel_mask    = paddr == `SSF_OFF_IRQ_MASK;
  wire logic addr_hit    = sel_level | sel_hyst | sel_window |
                           sel_status | sel_irq_sts | sel_mask;

  // Read data selection, narrow registers zero extended
  wire logic [31:0] rd_data =
    sel_level   ? {16'h0000, level_reg}          :
    sel_hyst    ? {16'h0000, hyst_reg}           :
    sel_window  ? {16'h0000, window_reg}         :
    sel_status  ? {16'h0000, status_reg}         :
    sel_irq_sts ? {29'h0000000, irq_sts}         :
    sel_mask    ? {29'h0000000, mask_reg}        :
                  `SSF_RST_DATA;

  // ****************************************************************
  // Configuration register next values
  // ****************************************************************

  // Written only at the completing access edge
  wire logic [`SSF_CFG_W-1:0] level_next =
    (wr_en & sel_level) ? pwdata[`SSF_CFG_W-1:0] : level_reg;
  wire logic [`SSF_CFG_W-1:0] hyst_next =
    (wr_en & sel_hyst) ? pwdata[`SSF_CFG_W-1:0] : hyst_reg;
  wire logic [`SSF_CFG_W-1:0] window_next =
    (wr_en & sel_window) ? pwdata[`SSF_CFG_W-1:0] : window_reg;
  wire logic [`SSF_IRQ_W-1:0] mask_next =
    (wr_en & sel_mask) ? pwdata[`SSF_IRQ_W-1:0] : mask_reg;

  // Write-one-to-clear of interrupt status
  wire logic [`SSF_IRQ_W-1:0] irq_clr =
    (wr_en & sel_irq_sts) ? pwdata[`SSF_IRQ_W-1:0] : `SSF_IRQ_NONE;

  // ****************************************************************
  // APB answer registers
  // ****************************************************************

  // Answer prepared in setup, ready in the access cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata_reg  <= `SSF_RST_DATA;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg  <= setup_phase ? rd_data : prdata_reg;
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase & ~addr_hit;
    end
  end

  // Configuration storage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      level_reg  <= `SSF_RST_LEVEL;
      hyst_reg   <= `SSF_RST_HYST;
      window_reg <= `SSF_RST_WINDOW;
      mask_reg   <= `SSF_RST_MASK;
    end
    else
    begin
      level_reg  <= level_next;
      hyst_reg   <= hyst_next;
      window_reg <= window_next;
      mask_reg   <= mask_next;
    end
  end

  // ****************************************************************
  // Speed detection
  // ****************************************************************

  // Hysteresis comparator stepped by the control cycle
  ssf_speed_detect u_speed
  (
    .clk       (clk),
    .srst      (srst),
    .update    (ctrl_cycle_tick),
    .speed     (drive_fb.motor_speed),
    .level     (level_reg),
    .hyst      (hyst_reg),
    .flag      (speed_flag),
    .flag_next (speed_flag_next)
  );

  // ****************************************************************
  // Zero-point re-detection handshake
  // ****************************************************************

  // Done only after finish seen while requested
  always_comb
  begin
    redet_next = redet_reg;
    unique case (redet_reg)
      SSF_RD_IDLE:
      begin
        if (redetect_request)
          redet_next = SSF_RD_BUSY;
      end
      SSF_RD_BUSY:
      begin
        if (!redetect_request)
          redet_next = SSF_RD_IDLE;
        else if (drive_fb.redetect_finished)
          redet_next = SSF_RD_DONE;
      end
      SSF_RD_DONE:
      begin
        if (!redetect_request)
          redet_next = SSF_RD_IDLE;
      end
      default:
        redet_next = SSF_RD_IDLE;
    endcase
  end

  // Handshake state and busy indication
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      redet_reg         <= SSF_RD_IDLE;
      redetect_busy_reg <= 1'b0;
    end
    else
    begin
      redet_reg         <= redet_next;
      redetect_busy_reg <= redet_next == SSF_RD_BUSY;
    end
  end

  // ****************************************************************
  // Second in-position window
  // ****************************************************************

  // Droop magnitude against window, servo state ignored
  wire logic [16:0] droop_ext = {drive_fb.position_droop[15], drive_fb.position_droop};
  wire logic [16:0] droop_abs = drive_fb.position_droop[15] ?
                                (17'h00000 - droop_ext) : droop_ext;
  wire logic        inpos2    = droop_abs <= {1'b0, window_reg};

  // ****************************************************************
  // Status word assembly
  // ****************************************************************

  // Set one versus set two follow the loop's selection
  wire logic exc2  = drive_fb.excitation_set2_in_use;
  wire logic gain2 = drive_fb.gain_set2_in_use;
  // Boost only while requested and observer active
  wire logic boost = holding_boost_request & drive_fb.observer_running;

  // Next snapshot; maintenance bits held at zero
  always_comb
  begin
    status_next                        = status_reg;
    status_next.second_inposition_flag = inpos2;
    status_next.holding_boost_active   = boost;
    status_next.zero_redetect_done     = redet_next == SSF_RD_DONE;
    status_next.gain_set2_active       = gain2;
    status_next.excitation_set2_active = exc2;
    status_next.maint_hi               = `SSF_MAINT_HI_ZERO;
    status_next.speed_detect_output    = speed_flag_next;
    status_next.maint_lo               = 1'b0;
  end

  // One consistent snapshot per control cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      status_reg <= `SSF_RST_STATUS;
    else if (ctrl_cycle_tick)
      status_reg <= status_next;
  end

  // ****************************************************************
  // Interrupt events
  // ****************************************************************

  // Events seen at the snapshot edge
  // Compared with the comparator's own flag, so the first tick after reset is an event only if that flag itself changes
  wire logic ev_speed = speed_flag_next ^ speed_flag;
  wire logic ev_redet = status_next.zero_redetect_done & ~status_reg.zero_redetect_done;
  wire logic ev_inpos = status_next.second_inposition_flag &
                        ~status_reg.second_inposition_flag;

  // Event vector in status bit layout
  wire logic [`SSF_IRQ_W-1:0] irq_set =
    ctrl_cycle_tick ? {ev_inpos, ev_redet, ev_speed} : `SSF_IRQ_NONE;

  // Sticky bits, a new event beats a clear
  ssf_sticky
  #(
    .WIDTH (`SSF_IRQ_W)
  )
  u_irq_sts
  (
    .clk  (clk),
    .srst (srst),
    .set  (irq_set),
    .clr  (irq_clr),
    .sts  (irq_sts)
  );

  // Masked interrupt level
  wire logic irq_next = |(irq_sts & mask_reg);

  // Interrupt output register
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All outputs straight from flip-flops
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign status_word   = status_reg;
  assign redetect_busy = redetect_busy_reg;
  assign irq           = irq_reg;

endmodule

// ===== verification/ssf_asserts.sv
// Port checker for the spindle status flag block
module ssf_asserts
  import ssf_pkg::*;
(
  // Clock and reset
  input logic                   clk,
  input logic                   srst,
  // APB
  input logic [7:0]             paddr,
  input logic                   psel,
  input logic                   penable,
  input logic                   pwrite,
  input logic [31:0]            pwdata,
  input logic [31:0]            prdata,
  input logic                   pready,
  input logic                   pslverr,
  // Controller and drive
  input logic                   redetect_request,
  input logic                   holding_boost_request,
  input ssf_pkg::ssf_status_t   status_word,
  input logic                   ctrl_cycle_tick,
  input ssf_pkg::ssf_drive_fb_t drive_fb,
  input logic                   redetect_busy,
  input logic                   irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Boost cause seen by the snapshot
  wire boost_cause = holding_boost_request && drive_fb.observer_running;
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one access cycle");
  a_unmapped_err: assert property (pready && (paddr > 8'h14 || paddr[1:0] != 2'b00)
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_snapshot_hold: assert property (!$past(ctrl_cycle_tick) |-> $stable(status_word))
    else $error("status changed between ticks");
  a_boost_follow: assert property (ctrl_cycle_tick |=>
    status_word.holding_boost_active == $past(boost_cause))
    else $error("boost flag wrong");
  a_gain_follow: assert property (ctrl_cycle_tick |=>
    status_word.gain_set2_active == $past(drive_fb.gain_set2_in_use))
    else $error("gain indicator wrong");
  a_excit_follow: assert property (ctrl_cycle_tick |=>
    status_word.excitation_set2_active == $past(drive_fb.excitation_set2_in_use))
    else $error("excitation indicator wrong");
  a_inpos_zero: assert property (ctrl_cycle_tick && drive_fb.position_droop == 16'h0000
    |=> status_word.second_inposition_flag)
    else $error("zero droop not in position");
  a_done_drop: assert property (ctrl_cycle_tick && !redetect_request && !$past(redetect_request)
    |=> !status_word.zero_redetect_done)
    else $error("done flag without request");
  a_busy_request: assert property (redetect_busy |-> $past(redetect_request))
    else $error("busy without request");
  c_done: cover property ($rose(status_word.zero_redetect_done));
  c_irq: cover property ($rose(irq));
  c_refused: cover property (pready && pslverr);
endmodule

bind ssf_top ssf_asserts i_chk (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .redetect_request(redetect_request),
  .holding_boost_request(holding_boost_request), .status_word(status_word),
  .ctrl_cycle_tick(ctrl_cycle_tick), .drive_fb(drive_fb), .redetect_busy(redetect_busy),
  .irq(irq));

// ===== verification/ssf_nc_model.sv
// Numerical controller model: request levels out, status flags in
module ssf_nc_model
  import ssf_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Commands from the bench
  input  wire logic         want_redet,
  input  wire logic         want_boost,
  // Drive side
  input  ssf_pkg::ssf_status_t status_word,
  output logic              redetect_request = 1'b0,
  output logic              holding_boost_request = 1'b0,
  output logic [15:0]       flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Request levels and flag view
  // ****
  // Requests change just after an edge
  always @(posedge clk)
  begin
    redetect_request <= srst ? 1'b0 : want_redet;
    holding_boost_request <= srst ? 1'b0 : want_boost;
  end
  // Maintenance bits hidden from the controller
  assign flags = status_word & 16'hF802;
endmodule

// ===== verification/ssf_top_tb.sv
// Self-checking bench for the spindle status flag block
module ssf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssf_pkg::*;
  // ****
  // Signals and tables
  // ****
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic [7:0]    paddr = 8'h00;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          tick = 1'b0;
  logic [2:0]    tcnt = 3'h0;
  ssf_drive_fb_t fb = '0;
  logic          want_redet = 1'b0;
  logic          want_boost = 1'b0;
  logic          req;
  logic          boost;
  ssf_status_t   sw;
  logic          busy;
  logic          irq;
  logic [15:0]   flags;
  logic [31:0]   rd;
  logic          err;
  int            n_fail = 0;
  int            samples_checked = 0;
  int            cyc = 0;
  logic [7:0]    ra[4] = '{8'h00, 8'h04, 8'h08, 8'h14};
  logic [31:0]   rv[4] = '{32'h64, 32'h14, 32'h5, 32'h2};
  logic [15:0]   sp[7] = '{16'h0032, 16'h0079, 16'h006E, 16'hFF9D, 16'hFF88, 16'hFF87, 16'h0063};
  logic [6:0]    sx = 7'h59;
  logic [15:0]   dp[4] = '{16'h0005, 16'hFFFB, 16'h0006, 16'hFFFA};
  logic [3:0]    dx = 4'h3;

  ssf_top i_dut (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .redetect_request(req), .holding_boost_request(boost), .status_word(sw),
    .ctrl_cycle_tick(tick), .drive_fb(fb), .redetect_busy(busy), .irq(irq));
  ssf_nc_model i_nc (.clk(clk), .srst(srst), .want_redet(want_redet), .want_boost(want_boost),
    .status_word(sw), .redetect_request(req), .holding_boost_request(boost), .flags(flags));

  // 25 MHz clock
  always #20 clk = ~clk;
  // Control cycle strobe every eight clocks
  always @(posedge clk)
  begin
    tcnt <= srst ? 3'h0 : tcnt + 3'h1;
    tick <= !srst && tcnt == 3'h7;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic tk(input int n);
    repeat (n * 8) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rdc(ra[i], 32'h0, "reset value");
      apb(1'b1, ra[i], rv[i]);
      rdc(ra[i], rv[i], "readback");
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test registers done");
    for (int i = 0; i < 7; i++)
    begin
      fb.motor_speed <= sp[i];
      tk(2);
      chk(32'(flags[1]), 32'(sx[i]), "speed flag");
    end
    $display("test speed done");
    for (int i = 0; i < 16; i++)
    begin
      fb.excitation_set2_in_use <= i[3];
      fb.gain_set2_in_use <= i[2];
      fb.observer_running <= i[1];
      want_boost <= i[0];
      tk(2);
      chk(32'(flags[11]), 32'(i[3]), "excitation");
      chk(32'(flags[12]), 32'(i[2]), "gain");
      chk(32'(flags[14]), 32'(i[1] & i[0]), "boost");
    end
    $display("test indicators done");
    apb(1'b1, 8'h10, 32'h7);
    want_redet <= 1'b1;
    tk(2);
    chk(32'(busy), 32'h1, "busy");
    chk(32'(flags[13]), 32'h0, "done early");
    fb.redetect_finished <= 1'b1;
    @(posedge clk);
    fb.redetect_finished <= 1'b0;
    tk(2);
    chk(32'(flags[13]), 32'h1, "done");
    chk(32'(busy), 32'h0, "busy after done");
    chk(32'(irq), 32'h1, "irq raised");
    rdc(8'h10, 32'h2, "irq status");
    apb(1'b1, 8'h10, 32'h2);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
    want_redet <= 1'b0;
    tk(2);
    chk(32'(flags[13]), 32'h0, "done dropped");
    fb.redetect_finished <= 1'b1;
    @(posedge clk);
    fb.redetect_finished <= 1'b0;
    tk(2);
    chk(32'(flags[13]), 32'h0, "finish when idle");
    $display("test redetect done");
    for (int i = 0; i < 4; i++)
    begin
      fb.position_droop <= dp[i];
      tk(2);
      chk(32'(flags[15]), 32'(dx[i]), "in position");
    end
    $display("test in position done");
    wrap_up();
  end
endmodule
